/* verilog/test_mux_pattern_defs.svh */
`ifndef TEST_MUX_PATTERN_DEFS_SVH
`define TEST_MUX_PATTERN_DEFS_SVH

// register offsets (7-bit spi address)
`define SKEW_TEST_OFFSET 7'h18
`define TEMP_DIODE_OFFSET 7'h19
`define PLAY_CTRL_OFFSET 7'h1e
`define PATTERN_PORT_OFFSET 7'h1f

// reset values
`define SKEW_TEST_RESET 7'h00
`define TEMP_DIODE_RESET 2'h0
`define PLAY_CTRL_RESET 1'h0

// skew test field positions
`define PAIR_INVERT_BIT 0
`define PAIR_ADDR_LSB 1
`define PAIR_ADDR_MSB 5
`define SKEW_MUX_EN_BIT 6

// temperature diode field positions
`define TEMP_DIODE_EN_BIT 0
`define TEMP_DIODE_SEL_BIT 1

// playback control field position
`define PLAY_EN_BIT 0

// pattern memory geometry
`define PATTERN_SAMPLES 64
`define PATTERN_BYTES 128
`define PATTERN_PTR_W 7

// spi framing
`define SPI_READ_FLAG_BIT 7
`define SPI_LAST_BIT 3'h7

`endif

/* verilog/test_mux_pattern_pkg.sv */
`default_nettype none
package test_mux_pattern_pkg;

	// phase of an spi frame
	typedef enum logic [1:0] {
		ph_command,
		ph_write,
		ph_read
	} spi_phase_t;

	typedef logic [7:0] byte_t;
	typedef logic [15:0] sample_t;

endpackage
`default_nettype wire

/* verilog/lvds_test_mux_pattern_gen.sv */
`timescale 1ns/1ps
`default_nettype none
`include "test_mux_pattern_defs.svh"

module lvds_test_mux_pattern_gen
	import test_mux_pattern_pkg::*;
(
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// spi port
	input wire logic spi_sck_in,
	input wire logic spi_cs_n_in,
	input wire logic spi_sdi_in,
	output logic spi_sdo_out,
	output logic spi_sdo_oe_out,
	// lvds pins seen by the skew mux
	input wire logic [15:0] input_port_a_in,
	input wire logic [15:0] input_port_b_in,
	input wire logic input_data_clock_in,
	// synchronised lvds data path
	input wire logic data_enable_in,
	input wire logic [15:0] lvds_sample_in,
	// dac core feed
	output logic [15:0] dac_sample_out,
	output logic dac_sample_valid_out,
	output logic pattern_source_out,
	// analog test pin controls
	output logic skew_mux_level_out,
	output logic skew_mux_enable_out,
	output logic temp_diode_enable_out,
	output logic temp_diode_choice_out
);

	// picks the compared signal from the chain a15..a0, dck, b15..b0
	function automatic logic skew_pick(
		input logic [32:0] chain,
		input logic [4:0] code,
		input logic invert
	);
		logic [5:0] idx;
		idx = 6'h00;
		if (invert) begin
			idx = 6'h20 - {1'b0, code};
			skew_pick = ~chain[idx];
		end else begin
			idx = 6'h1f - {1'b0, code};
			skew_pick = chain[idx];
		end
	endfunction

	// registers
	logic [6:0] skew_test_reg;
	logic [1:0] temp_diode_reg;
	logic play_ctrl_reg;

	// pin synchronisers
	logic sck_s1_reg, sck_s2_reg, sck_s3_reg;
	logic cs_n_s1_reg, cs_n_s2_reg;
	logic sdi_s1_reg, sdi_s2_reg;
	logic [32:0] chain_s1_reg, chain_s2_reg;

	// spi engine
	spi_phase_t phase_reg;
	logic [2:0] bit_cnt_reg;
	byte_t shift_reg;
	byte_t tx_reg;
	logic [6:0] addr_reg;
	logic sck_rise, sck_fall, cs_active;
	logic byte_done;
	byte_t rx_byte;

	// pattern memory
	byte_t pat_mem [`PATTERN_BYTES];
	logic [`PATTERN_PTR_W-1:0] ptr_reg;
	logic mem_access;
	logic playing;

	always_ff @(posedge mclk_in) begin
		sck_s1_reg <= spi_sck_in;
		sck_s2_reg <= sck_s1_reg;
		sck_s3_reg <= sck_s2_reg;
		cs_n_s1_reg <= spi_cs_n_in;
		cs_n_s2_reg <= cs_n_s1_reg;
		sdi_s1_reg <= spi_sdi_in;
		sdi_s2_reg <= sdi_s1_reg;
	end

	always_ff @(posedge mclk_in) begin
		chain_s1_reg <= {input_port_a_in, input_data_clock_in, input_port_b_in};
		chain_s2_reg <= chain_s1_reg;
	end

	assign cs_active = ~cs_n_s2_reg;
	assign sck_rise = cs_active & sck_s2_reg & ~sck_s3_reg;
	assign sck_fall = cs_active & ~sck_s2_reg & sck_s3_reg;
	assign byte_done = sck_rise && (bit_cnt_reg == `SPI_LAST_BIT);
	assign rx_byte = {shift_reg[6:0], sdi_s2_reg};
	assign mem_access = byte_done && (phase_reg != ph_command)
		&& (addr_reg == `PATTERN_PORT_OFFSET);
	assign playing = play_ctrl_reg & data_enable_in;

	// register readback
	function automatic byte_t read_mux(
		input logic [6:0] addr,
		input logic [6:0] skew,
		input logic [1:0] temp,
		input logic play,
		input byte_t mem_byte
	);
		unique case (addr)
			`SKEW_TEST_OFFSET: read_mux = {1'b0, skew};
			`TEMP_DIODE_OFFSET: read_mux = {6'h00, temp};
			`PLAY_CTRL_OFFSET: read_mux = {7'h00, play};
			`PATTERN_PORT_OFFSET: read_mux = mem_byte;
			default: read_mux = 8'h00;
		endcase
	endfunction

	// a completed data byte of a write frame aimed at one address
	function automatic logic write_hit(
		input logic done,
		input spi_phase_t phase,
		input logic [6:0] addr,
		input logic [6:0] target
	);
		write_hit = done && (phase == ph_write) && (addr == target);
	endfunction

	// bit position within the current byte
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in || !cs_active) begin
			bit_cnt_reg <= 3'h0;
		end else if (sck_rise) begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
		end
	end

	// receive shifter, msb first
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in || !cs_active) begin
			shift_reg <= 8'h00;
		end else if (sck_rise) begin
			shift_reg <= rx_byte;
		end
	end

	// frame phase: command byte first, then data
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in || !cs_active) begin
			phase_reg <= ph_command;
		end else if (byte_done && phase_reg == ph_command) begin
			phase_reg <= rx_byte[`SPI_READ_FLAG_BIT] ? ph_read : ph_write;
		end
	end

	// address from the command, then stepped except at the pattern port
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in || !cs_active) begin
			addr_reg <= 7'h00;
		end else if (byte_done) begin
			if (phase_reg == ph_command) begin
				addr_reg <= rx_byte[6:0];
			end else if (addr_reg != `PATTERN_PORT_OFFSET) begin
				addr_reg <= addr_reg + 7'h01;
			end
		end
	end

	// sdo enable while the read data phase lasts
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in || !cs_active) begin
			spi_sdo_oe_out <= 1'b0;
		end else begin
			spi_sdo_oe_out <= (phase_reg == ph_read);
		end
	end

	// sdo moves on each falling sck of a read
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in || !cs_active) begin
			spi_sdo_out <= 1'b0;
		end else if (sck_fall && phase_reg == ph_read) begin
			spi_sdo_out <= tx_reg[7];
		end
	end

	// transmit byte: loaded at each completed command or read byte, shifted on falling sck
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in || !cs_active) begin
			tx_reg <= 8'h00;
		end else if (byte_done && phase_reg == ph_command) begin
			tx_reg <= read_mux(rx_byte[6:0], skew_test_reg, temp_diode_reg,
				play_ctrl_reg, pat_mem[ptr_reg]);
		end else if (byte_done && phase_reg == ph_read) begin
			if (addr_reg == `PATTERN_PORT_OFFSET) begin
				tx_reg <= pat_mem[ptr_reg + 7'h01];
			end else begin
				tx_reg <= read_mux(addr_reg + 7'h01, skew_test_reg, temp_diode_reg,
					play_ctrl_reg, pat_mem[ptr_reg]);
			end
		end else if (sck_fall && phase_reg == ph_read) begin
			tx_reg <= {tx_reg[6:0], 1'b0};
		end
	end

	// skew test register
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			skew_test_reg <= `SKEW_TEST_RESET;
		end else if (write_hit(byte_done, phase_reg, addr_reg, `SKEW_TEST_OFFSET)) begin
			skew_test_reg <= rx_byte[6:0];
		end
	end

	// temperature diode register
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			temp_diode_reg <= `TEMP_DIODE_RESET;
		end else if (write_hit(byte_done, phase_reg, addr_reg, `TEMP_DIODE_OFFSET)) begin
			temp_diode_reg <= rx_byte[1:0];
		end
	end

	// playback control register
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			play_ctrl_reg <= `PLAY_CTRL_RESET;
		end else if (write_hit(byte_done, phase_reg, addr_reg, `PLAY_CTRL_OFFSET)) begin
			play_ctrl_reg <= rx_byte[`PLAY_EN_BIT];
		end
	end

	// pattern memory fill, one byte per transfer, msb byte first
	always_ff @(posedge mclk_in) begin
		if (write_hit(byte_done, phase_reg, addr_reg, `PATTERN_PORT_OFFSET)) begin
			pat_mem[ptr_reg] <= rx_byte;
		end
	end

	// shared pointer: bytes during spi access, samples during playback
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			ptr_reg <= '0;
		end else if (playing) begin
			ptr_reg <= ptr_reg + 7'h02;
		end else if (mem_access) begin
			ptr_reg <= ptr_reg + 7'h01;
		end
	end

	// source flag for the dac core
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			pattern_source_out <= 1'b0;
		end else begin
			pattern_source_out <= play_ctrl_reg;
		end
	end

	// sample valid follows the data enable
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			dac_sample_valid_out <= 1'b0;
		end else begin
			dac_sample_valid_out <= data_enable_in;
		end
	end

	// dac sample: pattern, held at zero, or the lvds path
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			dac_sample_out <= 16'h0000;
		end else if (playing) begin
			dac_sample_out <= {pat_mem[ptr_reg], pat_mem[ptr_reg + 7'h01]};
		end else if (play_ctrl_reg) begin
			dac_sample_out <= 16'h0000;
		end else begin
			dac_sample_out <= lvds_sample_in;
		end
	end

	// selected lvds level for the test pins
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			skew_mux_level_out <= 1'b0;
		end else begin
			skew_mux_level_out <= skew_pick(chain_s2_reg,
				skew_test_reg[`PAIR_ADDR_MSB:`PAIR_ADDR_LSB],
				skew_test_reg[`PAIR_INVERT_BIT]);
		end
	end

	// skew mux connection
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			skew_mux_enable_out <= 1'b0;
		end else begin
			skew_mux_enable_out <= skew_test_reg[`SKEW_MUX_EN_BIT];
		end
	end

	// diode connection, held off while the skew mux owns the pins
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			temp_diode_enable_out <= 1'b0;
		end else begin
			temp_diode_enable_out <= temp_diode_reg[`TEMP_DIODE_EN_BIT]
				& ~skew_test_reg[`SKEW_MUX_EN_BIT];
		end
	end

	// diode choice
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in) begin
			temp_diode_choice_out <= 1'b0;
		end else begin
			temp_diode_choice_out <= temp_diode_reg[`TEMP_DIODE_SEL_BIT];
		end
	end

endmodule // lvds_test_mux_pattern_gen
`default_nettype wire

/* testbench/lvds_test_mux_pattern_gen_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module lvds_test_mux_pattern_gen_asserts (
	// clock and reset
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// watched ports
	input wire logic spi_cs_n_in,
	input wire logic spi_sdo_oe_out,
	input wire logic data_enable_in,
	input wire logic [15:0] lvds_sample_in,
	input wire logic [15:0] dac_sample_out,
	input wire logic dac_sample_valid_out,
	input wire logic pattern_source_out,
	input wire logic skew_mux_enable_out,
	input wire logic temp_diode_enable_out,
	input wire logic temp_diode_choice_out
);
	logic [6:0] run_reg;
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);
	// consecutive playback cycles
	always_ff @(posedge mclk_in) begin
		if (!rst_n_in || !(pattern_source_out && dac_sample_valid_out))
			run_reg <= 7'h00;
		else if (run_reg != 7'h7f)
			run_reg <= run_reg + 7'h01;
	end
	sequence s_cs_idle;
		spi_cs_n_in [*6];
	endsequence
	property p_rst;
		disable iff (1'b0) !rst_n_in |=> !skew_mux_enable_out && !temp_diode_enable_out
			&& !temp_diode_choice_out && !pattern_source_out && !dac_sample_valid_out;
	endproperty
	property p_valid;
		$past(rst_n_in) |-> dac_sample_valid_out == $past(data_enable_in);
	endproperty
	property p_excl;
		skew_mux_enable_out |-> !temp_diode_enable_out;
	endproperty
	property p_zero;
		$past(rst_n_in) && pattern_source_out && !dac_sample_valid_out |-> dac_sample_out == 16'h0;
	endproperty
	property p_pass;
		$past(rst_n_in) && !pattern_source_out |-> dac_sample_out == $past(lvds_sample_in);
	endproperty
	property p_wrap;
		pattern_source_out && dac_sample_valid_out && run_reg >= 7'h42
			|-> dac_sample_out == $past(dac_sample_out, 64);
	endproperty
	property p_oe_idle;
		s_cs_idle |-> !spi_sdo_oe_out;
	endproperty
	property p_cfg_hold;
		s_cs_idle ##0 $past(rst_n_in) |-> $stable(skew_mux_enable_out)
			&& $stable(temp_diode_choice_out);
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
	a_valid: assert property (p_valid) else $error("valid not a copy of enable");
	a_excl: assert property (p_excl) else $error("diode on with mux");
	a_zero: assert property (p_zero) else $error("halted output not zero");
	a_pass: assert property (p_pass) else $error("lvds sample not passed");
	a_wrap: assert property (p_wrap) else $error("pattern period not 64");
	a_oe_idle: assert property (p_oe_idle) else $error("sdo driven while idle");
	a_cfg_hold: assert property (p_cfg_hold) else $error("config moved while idle");
endmodule // lvds_test_mux_pattern_gen_asserts
bind lvds_test_mux_pattern_gen lvds_test_mux_pattern_gen_asserts u_asserts (
	.mclk_in(mclk_in), .rst_n_in(rst_n_in), .spi_cs_n_in(spi_cs_n_in),
	.spi_sdo_oe_out(spi_sdo_oe_out), .data_enable_in(data_enable_in),
	.lvds_sample_in(lvds_sample_in), .dac_sample_out(dac_sample_out),
	.dac_sample_valid_out(dac_sample_valid_out), .pattern_source_out(pattern_source_out),
	.skew_mux_enable_out(skew_mux_enable_out), .temp_diode_enable_out(temp_diode_enable_out),
	.temp_diode_choice_out(temp_diode_choice_out));
`default_nettype wire

/* testbench/spi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input wire logic mclk_in,
	input wire logic sdo_in,
	output logic sck_out,
	output logic cs_n_out,
	output logic sdi_out
);
	logic [7:0] tx_q[$];
	logic [7:0] rx_q[$];
	initial begin
		sck_out = 1'b0;
		cs_n_out = 1'b1;
		sdi_out = 1'b0;
	end
	// mode 0, msb first, halves of 5 cycles
	task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sdi_out = tx[i];
			repeat (5) @(negedge mclk_in);
			rx[i] = sdo_in;
			sck_out = 1'b1;
			repeat (5) @(negedge mclk_in);
			sck_out = 1'b0;
		end
	endtask
	task automatic frame(input logic [7:0] cmd);
		logic [7:0] r;
		cs_n_out = 1'b0;
		repeat (4) @(negedge mclk_in);
		xbyte(cmd, r);
		while (tx_q.size() > 0) begin
			xbyte(tx_q.pop_front(), r);
			rx_q.push_back(r);
		end
		repeat (4) @(negedge mclk_in);
		cs_n_out = 1'b1;
		sdi_out = ~sdi_out;
		repeat (6) @(negedge mclk_in);
	endtask
endmodule // spi_host_model
`default_nettype wire

/* testbench/lvds_test_mux_pattern_gen_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_errors++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module lvds_test_mux_pattern_gen_tb;
	import test_mux_pattern_pkg::*;
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic sck, cs_n, sdi, sdo, oe, dval, psrc, lvl, men, ten, tch;
	logic [15:0] pa = 16'h0, pb = 16'h0, lv = 16'h0, dout;
	logic dck = 1'b0, den = 1'b0;
	int n_errors = 0, comparisons = 0, cyc = 0, rot = 0;
	sample_t pat[64];
	byte_t v, d;
	always #2.5 mclk_in = ~mclk_in;
	always @(negedge mclk_in) lv <= 16'($urandom);
	spi_host_model u_spi_host_model (.mclk_in(mclk_in), .sdo_in(sdo), .sck_out(sck),
		.cs_n_out(cs_n), .sdi_out(sdi));
	lvds_test_mux_pattern_gen u_lvds_test_mux_pattern_gen (.mclk_in(mclk_in),
		.rst_n_in(rst_n_in), .spi_sck_in(sck), .spi_cs_n_in(cs_n), .spi_sdi_in(sdi),
		.spi_sdo_out(sdo), .spi_sdo_oe_out(oe), .input_port_a_in(pa), .input_port_b_in(pb),
		.input_data_clock_in(dck), .data_enable_in(den), .lvds_sample_in(lv),
		.dac_sample_out(dout), .dac_sample_valid_out(dval), .pattern_source_out(psrc),
		.skew_mux_level_out(lvl), .skew_mux_enable_out(men), .temp_diode_enable_out(ten),
		.temp_diode_choice_out(tch));
	task automatic wr(input byte_t a, input byte_t x);
		u_spi_host_model.tx_q.push_back(x);
		u_spi_host_model.frame({1'b0, a[6:0]});
	endtask
	task automatic rd(input byte_t a, input int n);
		u_spi_host_model.rx_q = {};
		repeat (n) u_spi_host_model.tx_q.push_back(8'h00);
		u_spi_host_model.frame({1'b1, a[6:0]});
	endtask
	function automatic logic exp_lvl(input logic [4:0] c, input logic inv);
		logic [32:0] ch;
		ch = {pa, dck, pb};
		return inv ? ~ch[32 - c] : ch[31 - c];
	endfunction
	function automatic byte_t pat_byte(input int i);
		return i[0] ? pat[(i / 2) % 64][7:0] : pat[(i / 2) % 64][15:8];
	endfunction
	task automatic finish_test();
		$display("n_errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 80000) begin
			n_errors++;
			finish_test();
		end
	end
	initial begin
		void'($urandom(32'h1ee1b78e));
		repeat (3) @(negedge mclk_in);
		rst_n_in = 1'b1;
		repeat (4) @(negedge mclk_in);
		rd(8'h18, 2);
		`CHK("skew_rst", 8'h00, u_spi_host_model.rx_q[0])
		`CHK("temp_rst", 8'h00, u_spi_host_model.rx_q[1])
		for (int k = 0; k < 64; k++) begin
			{pa, pb, dck} = {$urandom, 1'($urandom)};
			wr(8'h18, {2'b01, 5'(k >> 1), 1'(k)});
			`CHK("level", exp_lvl(5'(k >> 1), 1'(k)), lvl)
		end
		// first pass breaks the host's exclusion on purpose
		for (int k = 0; k < 6; k++) begin
			v = (k == 0) ? 8'hc0 : 8'($urandom);
			d = (k == 0) ? 8'hff : 8'($urandom);
			u_spi_host_model.tx_q.push_back(v);
			wr(8'h18, d);
			`CHK("mux_en", v[6], men)
			`CHK("diode_en", d[0] & ~v[6], ten)
			`CHK("diode_sel", d[1], tch)
			rd(8'h18, 3);
			`CHK("skew_rd", {1'b0, v[6:0]}, u_spi_host_model.rx_q[0])
			`CHK("temp_rd", {6'h0, d[1:0]}, u_spi_host_model.rx_q[1])
			`CHK("unmapped", 8'h00, u_spi_host_model.rx_q[2])
		end
		wr(8'h18, 8'h00);
		wr(8'h1e, 8'h00);
		foreach (pat[i]) pat[i] = (i == 0) ? 16'hffff : {8'($urandom), 8'($urandom) & 8'he0};
		for (int i = 0; i < 128; i++) begin
			u_spi_host_model.tx_q.push_back(i[0] ? pat[i/2][7:0] : pat[i/2][15:8]);
			if (i < 10 || i == 127) u_spi_host_model.frame(8'h1f);
		end
		rd(8'h1f, 128);
		for (int i = 0; i < 128; i++)
			`CHK("readback", i[0] ? pat[i/2][7:0] : pat[i/2][15:8], u_spi_host_model.rx_q[i])
		wr(8'h1e, 8'h01);
		rd(8'h1e, 1);
		`CHK("play_rd", 8'h01, u_spi_host_model.rx_q[0])
		repeat (10) @(negedge mclk_in);
		den = 1'b1;
		for (int i = 0; i < 12 && dval !== 1'b1; i++) @(negedge mclk_in);
		`CHK("source", 1'b1, psrc)
		for (int i = 0; i < 140; i++) begin
			`CHK("play", pat[i % 64], dout)
			@(negedge mclk_in);
		end
		den = 1'b0;
		repeat (4) @(negedge mclk_in);
		`CHK("halt", 16'h0000, dout)
		wr(8'h1e, 8'h00);
		rd(8'h1f, 128);
		for (int i = 0; i < 64; i++)
			if ({u_spi_host_model.rx_q[2*i], u_spi_host_model.rx_q[2*i+1]} == 16'hffff)
				rot = i;
		for (int i = 0; i < 128; i++)
			`CHK("rotated", pat_byte(i + 128 - 2 * rot), u_spi_host_model.rx_q[i])
		finish_test();
	end
endmodule // lvds_test_mux_pattern_gen_tb
`default_nettype wire
